// File: rtl/uirc_pkg.sv
package uirc_pkg;

  // Operating clock
  localparam int CLK_FREQ_HZ = 25_000_000;

  // Register byte offsets
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_BAUD = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_TXDATA = 8'h10;
  localparam logic [7:0] ADDR_RXDATA = 8'h14;
  localparam logic [7:0] ADDR_CARRIER = 8'h18;
  localparam logic [7:0] ADDR_TXDMA = 8'h1C;
  localparam logic [7:0] ADDR_RXDMA = 8'h20;

  // Mode register field positions
  localparam int MODE_STOP_TWO = 0;
  localparam int MODE_PAR_ODD = 1;
  localparam int MODE_PAR_EN = 2;
  localparam int MODE_LEN8 = 3;
  localparam int MODE_INFRARED = 4;
  localparam int MODE_BAUD_DIV4 = 10;
  localparam int MODE_CARRIER_EN = 11;
  localparam int MODE_CARRIER_SEL = 12;
  localparam logic [15:0] MODE_WRITE_MASK = 16'h1C1F;

  // Control register field positions
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_SOFT_RESET = 1;

  // Status register field positions
  localparam int STAT_RX_ONE_FULL = 0;
  localparam int STAT_RX_TWO_FULL = 1;
  localparam int STAT_TX_EMPTY = 2;
  localparam int STAT_TX_BUSY = 3;
  localparam int STAT_RX_BUSY = 4;
  localparam int STAT_OVERRUN = 5;
  localparam int STAT_PARITY = 6;
  localparam int STAT_FRAMING = 7;
  localparam int STAT_TX_END = 8;

  // Reset values
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [11:0] BAUD_RESET = 12'h000;
  localparam logic [7:0] CARRIER_RESET = 8'h00;

  // Oversampling and infrared pulse timing, in sampling ticks
  localparam logic [4:0] OVERSAMPLE_DIV16 = 5'h10;
  localparam logic [4:0] OVERSAMPLE_DIV4 = 5'h04;
  localparam logic [4:0] IR_PULSE_TICKS = 5'h03;

  // Serial state machines, Gray coded along the frame
  typedef enum logic [2:0] {
    UIRC_TX_IDLE = 3'b000,
    UIRC_TX_START = 3'b001,
    UIRC_TX_DATA = 3'b011,
    UIRC_TX_PARITY = 3'b010,
    UIRC_TX_STOP = 3'b110
  } uirc_tx_state_t;

  typedef enum logic [2:0] {
    UIRC_RX_IDLE = 3'b000,
    UIRC_RX_START = 3'b001,
    UIRC_RX_DATA = 3'b011,
    UIRC_RX_PARITY = 3'b010,
    UIRC_RX_STOP = 3'b110
  } uirc_rx_state_t;

endpackage

// File: rtl/uirc_pin_sync.sv
module uirc_pin_sync #(
  parameter logic RESET_LEVEL = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // Pin side
  input wire logic pinIn,
  // Clean level
  output logic levelOut
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } uirc_sync_state_t;

  uirc_sync_state_t q, d;

  // Output moves only once the last two stages agree, rejecting one-stage glitches
  always_comb begin
    d = q;
    d.s1 = pinIn;
    d.s2 = q.s1;
    d.s3 = q.s2;
    if (q.s2 == q.s3) begin
      d.level = q.s3;
    end
  end

  // State register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q <= '{s1: RESET_LEVEL, s2: RESET_LEVEL, s3: RESET_LEVEL, level: RESET_LEVEL};
    end else if (ce) begin
      q <= d;
    end
  end

  assign levelOut = q.level;

endmodule // uirc_pin_sync

// File: rtl/uirc_rx_fifo.sv
module uirc_rx_fifo #(
  parameter int WIDTH = 10
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // Control
  input wire logic flush,
  input wire logic push,
  input wire logic [WIDTH-1:0] pushData,
  input wire logic pop,
  // Contents
  output logic [1:0] count,
  output logic [WIDTH-1:0] headData,
  output logic [WIDTH-1:0] nextData
);

  if (WIDTH < 1) begin : gWidthCheck
    $error("uirc_rx_fifo needs WIDTH of at least 1");
  end

  typedef struct packed {
    logic [1:0][WIDTH-1:0] entry;
    logic [1:0] count;
  } uirc_fifo_state_t;

  uirc_fifo_state_t q, d;

  // Two-entry queue; entry 0 is always the head, a pop shifts entry 1 down
  always_comb begin
    logic doPop;
    logic doPush;
    doPop = 1'b0;
    doPush = 1'b0;
    d = q;
    doPop = pop && (q.count != 2'd0);
    doPush = push && ((q.count != 2'd2) || doPop);
    if (flush) begin
      d.count = 2'd0;
    end else begin
      if (doPop) begin
        d.entry[0] = q.entry[1];
        d.count = 2'(q.count - 2'd1);
      end
      if (doPush) begin
        d.entry[d.count[0]] = pushData;
        d.count = 2'(d.count + 2'd1);
      end
    end
  end

  // State register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign count = q.count;
  assign headData = q.entry[0];
  assign nextData = q.entry[1];

endmodule // uirc_rx_fifo

// File: rtl/uirc_top.sv
// Summary of operation
// RQ1 - Transmit buffer empty with channel enable set raises that channel's transmit DMA request.
// RQ2 - DMA controller writes bytes to a fixed transmit data address, basic cycles.
// RQ3 - Low level on serial input starts reception and sets receive busy.
// RQ4 - At stop sample, busy clears and the character enters the receive buffer.
// RQ5 - Receive buffer is a two-entry queue accepting characters until full.
// RQ6 - First character sets one-full flag; a second unread one sets two-full.
// RQ7 - Software may take both buffered characters with two consecutive reads.
// RQ8 - One-full flag with channel enable set raises that channel's receive DMA request.
// RQ9 - DMA controller reads bytes from a fixed receive data address, basic cycles.
// RQ10 - Infrared mode routes both directions through the pulse modulator and demodulator.
// RQ11 - In infrared mode each low transmit bit becomes a 3/16 bit low pulse.
// RQ12 - In infrared mode short received low pulses are stretched to one bit.
// RQ13 - Software selects the 1/16 sampling ratio while infrared mode is used.
// RQ14 - Received infrared low pulses last at least three operating clock cycles.
// RQ15 - Carrier enable modulates the output during the selected data level.
// RQ16 - Carrier frequency is clock divided by twice the 8-bit period plus one.
// RQ17 - Stop bit sampled low flags framing error; character is still buffered.
// RQ18 - Error flag sets when the faulty character becomes the readable head.
// RQ19 - Parity mismatch still buffers the character and flags it when readable.
// RQ20 - A character finishing while both entries are unread is dropped, flagging overrun.
// RQ21 - Framing, parity and overrun flags serve as interrupt sources.
// RQ22 - Framing and parity flags clear by write one, faulty read, or soft reset.
// RQ23 - Software never enables infrared mode and carrier together.
// RQ24 - Carrier select one modulates high data periods, zero modulates low ones.
// RQ25 - Bits are sampled near their centre, timed from the start-bit edge.
module uirc_top
  import uirc_pkg::*;
#(
  parameter int DMA_CHANNELS = 4
) (
  // Clock, reset, clock enable
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial pins
  input wire logic serialInPin,
  output logic serialOutPin,
  // DMA requests, one per channel
  output logic [DMA_CHANNELS-1:0] txDmaRequest,
  output logic [DMA_CHANNELS-1:0] rxDmaRequest,
  // Error event levels: framing, parity, overrun
  output logic [2:0] errorSources
);

  if (DMA_CHANNELS < 1 || DMA_CHANNELS > 32) begin : gChanCheck
    $error("uirc_top supports 1 to 32 DMA channels");
  end

  typedef struct packed {
    logic [15:0] mode;
    logic [11:0] baud;
    logic enable;
    logic [7:0] carPeriod;
    logic [DMA_CHANNELS-1:0] txDmaEn;
    logic [DMA_CHANNELS-1:0] rxDmaEn;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic [7:0] baudCnt;
    uirc_tx_state_t txState;
    logic [7:0] txBuf;
    logic txFull;
    logic [7:0] txShift;
    logic [3:0] txBitIdx;
    logic [4:0] txPhase;
    logic txLine;
    logic txPar;
    logic txEnd;
    uirc_rx_state_t rxState;
    logic [4:0] rxPhase;
    logic [3:0] rxBitIdx;
    logic [7:0] rxShift;
    logic rxPar;
    logic rxBusy;
    logic demodLow;
    logic [4:0] demodCnt;
    logic [7:0] carCnt;
    logic carLevel;
    logic fe;
    logic pe;
    logic oe;
    logic serialOut;
    logic [DMA_CHANNELS-1:0] txDmaReq;
    logic [DMA_CHANNELS-1:0] rxDmaReq;
    logic [2:0] errSrc;
  } uirc_top_state_t;

  localparam uirc_top_state_t RESET_STATE = '{
    mode: MODE_RESET, baud: BAUD_RESET, carPeriod: CARRIER_RESET,
    txState: UIRC_TX_IDLE, rxState: UIRC_RX_IDLE,
    txLine: 1'b1, serialOut: 1'b1, default: '0};

  uirc_top_state_t q, d;

  logic syncIn;
  logic fifoPush;
  logic fifoPop;
  logic fifoFlush;
  logic [9:0] fifoPushWord;
  logic [1:0] fifoCount;
  logic [9:0] fifoHead;
  logic [9:0] fifoNext;

  // Serial input through the three-stage filter
  uirc_pin_sync #(
    .RESET_LEVEL(1'b1)
  ) uSync (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .pinIn(serialInPin),
    .levelOut(syncIn)
  );

  // Receive buffer; each word carries {parity error, framing error, data}
  uirc_rx_fifo #(
    .WIDTH(10)
  ) uFifo (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .flush(fifoFlush),
    .push(fifoPush),
    .pushData(fifoPushWord),
    .pop(fifoPop),
    .count(fifoCount),
    .headData(fifoHead),
    .nextData(fifoNext)
  );

  // Next-state logic for bus slave, baud ticks, transmitter, receiver and pin shaping
  always_comb begin
    logic access;
    logic done;
    logic mapped;
    logic [31:0] rdata;
    logic [15:0] status;
    logic [4:0] osLast;
    logic [4:0] halfLast;
    logic tick;
    logic [3:0] dataLast;
    logic rxIn;
    logic wrStatus;
    logic softReset;
    logic shaped;
    access = 1'b0;
    done = 1'b0;
    mapped = 1'b0;
    rdata = '0;
    status = '0;
    osLast = '0;
    halfLast = '0;
    tick = 1'b0;
    dataLast = '0;
    rxIn = 1'b1;
    wrStatus = 1'b0;
    softReset = 1'b0;
    shaped = 1'b1;
    d = q;
    fifoPush = 1'b0;
    fifoPop = 1'b0;
    fifoFlush = 1'b0;
    fifoPushWord = '0;

    // Frame geometry from the mode register
    osLast = q.mode[MODE_BAUD_DIV4] ? 5'(OVERSAMPLE_DIV4 - 5'h01) : 5'(OVERSAMPLE_DIV16 - 5'h01);
    halfLast = q.mode[MODE_BAUD_DIV4] ? 5'((OVERSAMPLE_DIV4 >> 1) - 5'h01) : 5'((OVERSAMPLE_DIV16 >> 1) - 5'h01);
    dataLast = q.mode[MODE_LEN8] ? 4'h7 : 4'h6;

    // Status word as software sees it
    status[STAT_RX_ONE_FULL] = (fifoCount != 2'd0); // RQ6
    status[STAT_RX_TWO_FULL] = (fifoCount == 2'd2); // RQ6
    status[STAT_TX_EMPTY] = !q.txFull;
    status[STAT_TX_BUSY] = (q.txState != UIRC_TX_IDLE);
    status[STAT_RX_BUSY] = q.rxBusy;
    status[STAT_OVERRUN] = q.oe;
    status[STAT_PARITY] = q.pe;
    status[STAT_FRAMING] = q.fe;
    status[STAT_TX_END] = q.txEnd;

    // Address decode and read mux
    mapped = 1'b1;
    unique case (paddr)
      ADDR_MODE: rdata = {16'h0000, q.mode};
      ADDR_BAUD: rdata = {20'h00000, q.baud};
      ADDR_CTRL: rdata = {31'h00000000, q.enable};
      ADDR_STATUS: rdata = {16'h0000, status};
      ADDR_TXDATA: rdata = {24'h000000, q.txBuf};
      ADDR_RXDATA: rdata = {24'h000000, fifoHead[7:0]};
      ADDR_CARRIER: rdata = {24'h000000, q.carPeriod};
      ADDR_TXDMA: rdata = 32'(q.txDmaEn);
      ADDR_RXDMA: rdata = 32'(q.rxDmaEn);
      default: mapped = 1'b0;
    endcase

    // One wait state: answer is prepared, then completes on the next edge
    access = psel && penable;
    done = access && q.pready;
    if (access && !q.pready) begin
      d.pready = 1'b1;
      d.prdata = (mapped && !pwrite) ? rdata : 32'h00000000; // Writes answer with zero data
      d.pslverr = !mapped;
    end else begin
      d.pready = 1'b0;
      d.pslverr = 1'b0;
    end

    // Register writes land at the completing edge
    if (done && pwrite && mapped) begin
      unique case (paddr)
        ADDR_MODE: d.mode = pwdata[15:0] & MODE_WRITE_MASK;
        ADDR_BAUD: d.baud = pwdata[11:0];
        ADDR_CTRL: begin
          d.enable = pwdata[CTRL_ENABLE];
          softReset = pwdata[CTRL_SOFT_RESET];
        end
        ADDR_STATUS: wrStatus = 1'b1;
        ADDR_CARRIER: d.carPeriod = pwdata[7:0];
        ADDR_TXDMA: d.txDmaEn = pwdata[DMA_CHANNELS-1:0];
        ADDR_RXDMA: d.rxDmaEn = pwdata[DMA_CHANNELS-1:0];
        default: ;
      endcase
    end

    // Write-one clears come first so that a same-cycle hardware set wins
    if (wrStatus) begin
      if (pwdata[STAT_FRAMING]) d.fe = 1'b0; // RQ22
      if (pwdata[STAT_PARITY]) d.pe = 1'b0; // RQ22
      if (pwdata[STAT_OVERRUN]) d.oe = 1'b0;
      if (pwdata[STAT_TX_END]) d.txEnd = 1'b0;
    end

    // Reading the receive data pops the head; a faulty head clears its flags
    if (done && !pwrite && paddr == ADDR_RXDATA && fifoCount != 2'd0) begin
      fifoPop = 1'b1; // RQ7
      if (fifoHead[8]) d.fe = 1'b0; // RQ22
      if (fifoHead[9]) d.pe = 1'b0; // RQ22
      // The second entry becomes readable now, so its errors show now
      if (fifoCount == 2'd2) begin
        if (fifoNext[8]) d.fe = 1'b1; // RQ18
        if (fifoNext[9]) d.pe = 1'b1; // RQ18
      end
    end

    // Sampling tick from the baud counter, running only while enabled
    if (q.enable) begin
      tick = (q.baudCnt == q.baud[7:0]);
      d.baudCnt = tick ? 8'h00 : 8'(q.baudCnt + 8'h01);
    end else begin
      d.baudCnt = 8'h00;
    end

    // Transmit data write; the buffer is single, so a write while full overwrites
    if (done && pwrite && paddr == ADDR_TXDATA) begin
      d.txBuf = pwdata[7:0];
      d.txFull = 1'b1;
    end

    // Transmitter: start, data LSB first, optional parity, one or two stops
    unique case (q.txState)
      UIRC_TX_IDLE: begin
        d.txLine = 1'b1;
        if (q.enable && q.txFull) begin
          d.txShift = q.txBuf;
          d.txPar = (^(q.txBuf & {q.mode[MODE_LEN8], 7'h7F})) ^ q.mode[MODE_PAR_ODD];
          d.txFull = (done && pwrite && paddr == ADDR_TXDATA); // Empty flag rises on load
          d.txState = UIRC_TX_START;
          d.txPhase = 5'h00;
          d.txLine = 1'b0;
        end
      end
      UIRC_TX_START, UIRC_TX_DATA, UIRC_TX_PARITY, UIRC_TX_STOP: begin
        if (tick) begin
          d.txPhase = 5'(q.txPhase + 5'h01);
          if (q.txPhase == osLast) begin
            d.txPhase = 5'h00;
            unique case (q.txState)
              UIRC_TX_START: begin
                d.txState = UIRC_TX_DATA;
                d.txBitIdx = 4'h0;
                d.txLine = q.txShift[0];
              end
              UIRC_TX_DATA: begin
                d.txShift = {1'b0, q.txShift[7:1]};
                d.txBitIdx = 4'(q.txBitIdx + 4'h1);
                if (q.txBitIdx == dataLast) begin
                  d.txBitIdx = 4'h0;
                  d.txState = q.mode[MODE_PAR_EN] ? UIRC_TX_PARITY : UIRC_TX_STOP;
                  d.txLine = q.mode[MODE_PAR_EN] ? q.txPar : 1'b1;
                end else begin
                  d.txLine = q.txShift[1];
                end
              end
              UIRC_TX_PARITY: begin
                d.txState = UIRC_TX_STOP;
                d.txLine = 1'b1;
              end
              default: begin
                d.txBitIdx = 4'(q.txBitIdx + 4'h1);
                if (q.txBitIdx[0] == q.mode[MODE_STOP_TWO]) begin
                  d.txState = UIRC_TX_IDLE;
                  d.txBitIdx = 4'h0;
                  if (!q.txFull) d.txEnd = 1'b1;
                end
              end
            endcase
          end
        end
      end
      default: d.txState = UIRC_TX_IDLE;
    endcase

    // Demodulator holds a short infrared low pulse for one whole bit
    if (!q.demodLow) begin
      if (!syncIn) begin
        d.demodLow = 1'b1; // RQ12
        d.demodCnt = 5'h00;
      end
    end else if (tick) begin
      d.demodCnt = 5'(q.demodCnt + 5'h01);
      if (q.demodCnt == osLast) begin
        d.demodLow = 1'b0; // RQ12
      end
    end
    rxIn = q.mode[MODE_INFRARED] ? !q.demodLow : syncIn; // RQ10

    // Receiver: start check at half bit, then samples one bit apart at centres
    unique case (q.rxState)
      UIRC_RX_IDLE: begin
        if (q.enable && !rxIn) begin
          d.rxState = UIRC_RX_START; // RQ3
          d.rxBusy = 1'b1; // RQ3
          d.rxPhase = 5'h00;
          d.rxPar = 1'b0;
        end
      end
      UIRC_RX_START: begin
        if (tick) begin
          d.rxPhase = 5'(q.rxPhase + 5'h01);
          if (q.rxPhase == halfLast) begin
            d.rxPhase = 5'h00;
            if (rxIn) begin
              d.rxState = UIRC_RX_IDLE; // False start: a glitch, not a frame
              d.rxBusy = 1'b0;
            end else begin
              d.rxState = UIRC_RX_DATA; // RQ25
              d.rxBitIdx = 4'h0;
            end
          end
        end
      end
      UIRC_RX_DATA, UIRC_RX_PARITY, UIRC_RX_STOP: begin
        if (tick) begin
          d.rxPhase = 5'(q.rxPhase + 5'h01);
          if (q.rxPhase == osLast) begin
            d.rxPhase = 5'h00; // RQ25
            unique case (q.rxState)
              UIRC_RX_DATA: begin
                d.rxShift = {rxIn, q.rxShift[7:1]}; // RQ3
                d.rxPar = q.rxPar ^ rxIn;
                d.rxBitIdx = 4'(q.rxBitIdx + 4'h1);
                if (q.rxBitIdx == dataLast) begin
                  d.rxState = q.mode[MODE_PAR_EN] ? UIRC_RX_PARITY : UIRC_RX_STOP;
                end
              end
              UIRC_RX_PARITY: begin
                d.rxPar = q.rxPar ^ rxIn;
                d.rxState = UIRC_RX_STOP;
              end
              default: begin
                // Only the first stop bit is checked; a second one is idle line
                d.rxState = UIRC_RX_IDLE;
                d.rxBusy = 1'b0; // RQ4
                fifoPushWord[7:0] = q.mode[MODE_LEN8] ? q.rxShift : {1'b0, q.rxShift[7:1]};
                fifoPushWord[8] = !rxIn; // RQ17
                fifoPushWord[9] = q.mode[MODE_PAR_EN] && (q.rxPar ^ q.mode[MODE_PAR_ODD]); // RQ19
                if (fifoCount == 2'd2 && !fifoPop) begin
                  d.oe = 1'b1; // RQ20
                end else begin
                  fifoPush = 1'b1; // RQ4 RQ5
                  // Into an empty buffer the faulty character is readable at once
                  if (fifoCount == 2'd0 || (fifoCount == 2'd1 && fifoPop)) begin
                    if (fifoPushWord[8]) d.fe = 1'b1; // RQ18
                    if (fifoPushWord[9]) d.pe = 1'b1; // RQ18
                  end
                end
              end
            endcase
          end
        end
      end
      default: d.rxState = UIRC_RX_IDLE;
    endcase

    // Carrier square wave: half period lasts setting plus one clocks
    if (q.carCnt == q.carPeriod) begin
      d.carCnt = 8'h00;
      d.carLevel = !q.carLevel; // RQ16
    end else begin
      d.carCnt = 8'(q.carCnt + 8'h01);
    end

    // Output shaping; infrared and carrier are exclusive by software
    shaped = q.txLine;
    if (q.mode[MODE_INFRARED]) begin
      // Low bit becomes a short low pulse at the bit start, assumes 1/16 ticks
      shaped = !(!q.txLine && q.txPhase < IR_PULSE_TICKS); // RQ10 RQ11
    end else if (q.mode[MODE_CARRIER_EN] && q.txState != UIRC_TX_IDLE) begin
      if (q.txLine == q.mode[MODE_CARRIER_SEL]) begin
        shaped = q.carLevel; // RQ15 RQ24
      end
    end
    d.serialOut = shaped;

    // Software reset clears the datapath and flags, configuration is kept
    if (softReset) begin
      d.txState = UIRC_TX_IDLE;
      d.rxState = UIRC_RX_IDLE;
      d.txFull = 1'b0;
      d.txLine = 1'b1;
      d.txEnd = 1'b0;
      d.rxBusy = 1'b0;
      d.demodLow = 1'b0;
      d.fe = 1'b0; // RQ22
      d.pe = 1'b0; // RQ22
      d.oe = 1'b0;
      d.serialOut = 1'b1;
      fifoFlush = 1'b1;
    end

    // Registered request and event outputs; tx request and error sources use next-state flags, rx request uses current fifo count and q.rxDmaEn
    d.txDmaReq = (d.txFull ? '0 : d.txDmaEn); // RQ1
    d.rxDmaReq = ((fifoCount != 2'd0) && !fifoPop && !fifoFlush) ? q.rxDmaEn : '0; // RQ8
    if (fifoPush && fifoCount == 2'd0 && !fifoFlush) d.rxDmaReq = q.rxDmaEn; // RQ8
    d.errSrc = {d.oe, d.pe, d.fe}; // RQ21
  end

  // State register; the clock enable freezes everything
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q <= RESET_STATE;
    end else if (ce) begin
      q <= d;
    end
  end

  // Ports come straight from the state register
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign serialOutPin = q.serialOut;
  assign txDmaRequest = q.txDmaReq;
  assign rxDmaRequest = q.rxDmaReq;
  assign errorSources = q.errSrc;

endmodule // uirc_top

// File: dv/uirc_props.sv
module uirc_props
  import uirc_pkg::*;
#(
  parameter int DMA_CHANNELS = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and events
  input wire logic serialInPin,
  input wire logic serialOutPin,
  input wire logic [DMA_CHANNELS-1:0] txDmaRequest,
  input wire logic [DMA_CHANNELS-1:0] rxDmaRequest,
  input wire logic [2:0] errorSources
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Access phase still waiting for its answer
  sequence sWait;
    psel && penable && !pready;
  endsequence
  // Flags fall only after a bus transfer
  sequence sRecent;
    $past(pready) || $past(pready, 2) || $past(pready, 3);
  endsequence
  a_ready_answer: assert property (sWait |=> pready) else $error("no answer after access");
  a_ready_single: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  a_ready_cause: assert property (pready |-> $past(psel && penable)) else $error("pready without access");
  a_slverr_map: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > ADDR_RXDMA))
    else $error("pslverr wrong for address");
  a_write_zero: assert property (pready && pwrite |-> prdata == 32'h0) else $error("read data on write");
  a_reset_idle: assert property ($fell(reset) |-> serialOutPin && !pready && txDmaRequest == '0
    && rxDmaRequest == '0 && errorSources == 3'h0) else $error("outputs not idle after reset");
  a_overrun_hold: assert property (errorSources[2] && !(psel && pwrite) |=> errorSources[2])
    else $error("overrun flag lost");
  a_txdma_drop: assert property ($fell(txDmaRequest[0]) |-> sRecent)
    else $error("tx request fell without cause");
  a_rxdma_drop: assert property ($fell(rxDmaRequest[0]) |-> sRecent)
    else $error("rx request fell without cause");
  a_error_clear: assert property ($fell(errorSources[0]) || $fell(errorSources[1]) |-> sRecent)
    else $error("error flag fell without cause");
endmodule // uirc_props

bind uirc_top uirc_props #(.DMA_CHANNELS(DMA_CHANNELS)) uProps (.*);

// File: dv/uirc_peer.sv
module uirc_peer (
  // Clock
  input wire logic clk,
  // Line into the receiver, idle high
  output logic lineOut
);
  timeunit 1ns;
  timeprecision 1ns;
  initial lineOut = 1'b1;
  // One bit of n clocks; infrared lows are only a 3-clock pulse
  task automatic sendBit(input logic b, input logic ir, input int n);
    if (ir && !b) begin
      lineOut <= 1'b0;
      repeat (3) @(posedge clk);
      lineOut <= 1'b1;
      repeat (n - 3) @(posedge clk);
    end else begin
      lineOut <= b;
      repeat (n) @(posedge clk);
    end
  endtask
  // 8 data bits LSB first, even parity, one stop; faults on request
  task automatic sendFrame(input logic [7:0] d, input logic badPar, input logic badStop, input logic ir);
    sendBit(1'b0, ir, 16);
    for (int i = 0; i < 8; i++) sendBit(d[i], ir, 16);
    sendBit(^d ^ badPar, ir, 16);
    // A short low stop avoids a real start right after it
    if (badStop) sendBit(1'b0, 1'b0, 10);
    sendBit(1'b1, 1'b0, badStop ? 22 : 24);
  endtask
endmodule // uirc_peer

// File: dv/uirc_top_tb.sv
module uirc_top_tb;
  import uirc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // Flags f: bad parity, bad stop, infrared
  typedef struct packed {logic [7:0] d; logic [2:0] f;} uirc_row_t;
  localparam logic [31:0] BASE = (32'h1 << MODE_LEN8) | (32'h1 << MODE_PAR_EN);
  uirc_row_t rows [4] = '{'{8'hA5, 3'h0}, '{8'h00, 3'h4}, '{8'hFF, 3'h2}, '{8'h3C, 3'h1}};
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, serialInPin, serialOutPin;
  logic [3:0] txDmaRequest, rxDmaRequest;
  logic [2:0] errorSources;
  int n_errors = 0;
  int comparisons = 0;
  int lowLen;
  always #20 clk = ~clk;
  uirc_top #(.DMA_CHANNELS(4)) DUT (.ce(1'b1), .*);
  uirc_peer uPeer (.clk(clk), .lineOut(serialInPin));
  // One APB transfer
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Receive side of the status word
  function automatic logic [31:0] stat(logic one, logic two, logic ovr, logic pe, logic fe);
    return (32'(one) << STAT_RX_ONE_FULL) | (32'(two) << STAT_RX_TWO_FULL) | (32'(ovr) << STAT_OVERRUN)
      | (32'(pe) << STAT_PARITY) | (32'(fe) << STAT_FRAMING);
  endfunction
  // Clocks of the second low run
  task automatic lowRun();
    lowLen = -1;
    @(negedge serialOutPin);
    @(posedge serialOutPin);
    @(negedge serialOutPin);
    do begin
      @(posedge clk);
      lowLen++;
    end while (serialOutPin === 1'b0);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    give_verdict();
  end
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    apb(1'b0, ADDR_MODE, 32'h0);
    chk("mode reset", {16'h0, MODE_RESET}, rd);
    apb(1'b1, 8'h40, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    chk("tx dma off", 32'h0, {28'h0, txDmaRequest});
    apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_ENABLE);
    apb(1'b1, ADDR_RXDMA, 32'h1);
    apb(1'b1, ADDR_TXDMA, 32'h3);
    repeat (3) @(posedge clk);
    chk("tx dma on", 32'h3, {28'h0, txDmaRequest});
    foreach (rows[i]) begin
      apb(1'b1, ADDR_MODE, BASE | (32'(rows[i].f[0]) << MODE_INFRARED));
      uPeer.sendFrame(rows[i].d, rows[i].f[2], rows[i].f[1], rows[i].f[0]);
      chk("rx dma", 32'h1, {28'h0, rxDmaRequest});
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("status one", stat(1'b1, 1'b0, 1'b0, rows[i].f[2], rows[i].f[1]), rd & 32'hF3);
      apb(1'b0, ADDR_RXDATA, 32'h0);
      chk("rx data", {24'h0, rows[i].d}, rd);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("status read", 32'h0, rd & 32'hF3);
    end
    apb(1'b1, ADDR_MODE, BASE);
    uPeer.sendFrame(8'h11, 1'b0, 1'b0, 1'b0);
    uPeer.sendFrame(8'h22, 1'b1, 1'b0, 1'b0);
    uPeer.sendFrame(8'h33, 1'b0, 1'b0, 1'b0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status full", stat(1'b1, 1'b1, 1'b1, 1'b0, 1'b0), rd & 32'hF3);
    apb(1'b0, ADDR_RXDATA, 32'h0);
    chk("first byte", 32'h11, rd);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status head", stat(1'b1, 1'b0, 1'b1, 1'b1, 1'b0), rd & 32'hF3);
    chk("error sources", 32'h6, {29'h0, errorSources});
    apb(1'b0, ADDR_RXDATA, 32'h0);
    chk("second byte", 32'h22, rd);
    apb(1'b1, ADDR_STATUS, 32'h1 << STAT_OVERRUN);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("overrun clear", 32'h0, rd & 32'hF3);
    apb(1'b1, ADDR_MODE, BASE | (32'h1 << MODE_INFRARED));
    apb(1'b1, ADDR_TXDATA, 32'h0);
    lowRun();
    chk("ir pulse", 32'h3, lowLen);
    repeat (200) @(posedge clk);
    apb(1'b1, ADDR_CARRIER, 32'h4);
    apb(1'b1, ADDR_MODE, BASE | (32'h1 << MODE_CARRIER_EN));
    apb(1'b1, ADDR_TXDATA, 32'h0);
    lowRun();
    chk("carrier half", 32'h5, lowLen);
    give_verdict();
  end
endmodule // uirc_top_tb
